// ### include/scmr_pkg.sv
/*
  Constants and carrier types for the serial configuration memory reader.
  Assumes a single 50 MHz system clock; the four serial pins are asynchronous to it, the program port is not.
*/
// Notes on behaviour
// [R1] The FPGA clocks this memory and takes its serial data output.
// [R2] The system chains each cascade output into the next chip enable.
// [R3] Address counter clears while reset/output-enable sits at reset level, and on power-up reset.
// [R4] The FPGA issues up to about 16 million clocks before completion.
// [R5] Reset level from the FPGA reset line clears the bit pointer.
// [R6] The system programs inverted polarity for reset-line wiring.
// [R7] The FPGA enters master serial mode only with all mode selects low.
// [R8] One stored bit per valid rising config clock edge, in sequence.
// [R9] Held non-reset level keeps the counter so reading continues later.
// [R10] Power-up reset clears the address counter to the first bit.
// [R11] Edge after last bit drives cascade output low, disables data.
// [R12] Data output enables once chip enable is seen low.
// [R13] Inverted polarity: reset line low after completion clears counters.
// [R14] Chip enable high gives standby with data output floating.
// [R15] FPGA done disables memory data one clock before user I/O.
// [R16] With output enable tied inactive, system supplies separate counter reset.
// [R17] Counter advances only while chip enable and output enable active.
// [R18] Data floats whenever chip enable or output enable is inactive.
// [R19] Cascade low only when both enables active and past terminal count.
// [R20] Reset/output-enable polarity is selectable, high or low active.
// [R21] Counter sized to capacity; last bit address is terminal count.
package scmr_pkg;
  // ==========================================================
  // storage geometry
  localparam int WORD_W = 16;
  localparam int MEM_WORDS = 4096;
  localparam int WADDR_W = 12;
  localparam int BIT_ADDR_W = 16;
  localparam logic [BIT_ADDR_W-1:0] LAST_BIT = 16'hFFFF;
  localparam logic [BIT_ADDR_W-1:0] BIT_ADDR_RST = 16'h0000;
  localparam logic [3:0] WORD_LAST_IDX = 4'hF;
  localparam logic [WADDR_W:0] PF_END = 13'h1000;
  localparam logic [WADDR_W:0] PF_RST = 13'h0000;
  localparam int FIFO_DEPTH = 16;
  // ==========================================================
  // clock
  localparam int CLK_HZ = 50_000_000;

  typedef struct packed {
    logic config_clock;
    logic ce_n;
    logic reset_oe;
    logic pol_inv;
  } scmr_pins_t;
  // idle pins: clock low, chip disabled, reset level held until synced
  localparam scmr_pins_t PINS_RST = 4'h6;
endpackage

// ### verilog/scmr_reader.sv
/*
  Serial configuration memory reader with its prefetch FIFO.
  Assumes pins arrive asynchronously and the config clock is far slower
  than mclk_in, so the FIFO head is refilled between edges.
*/
`timescale 1ns/1ps

// ==========================================================
// prefetch fifo
module scmr_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;
  // full compare needs the count's own width; DEPTH does not fit in AW bits
  assign in_ready_out = (cnt_r != (AW+1)'(DEPTH)) & ~flush_in;
  assign out_valid_out = (cnt_r != '0) & ~flush_in;
  assign out_data_out = mem[rd_r];

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_r] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (flush_in) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_r + AW'(push);
      rd_r <= rd_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==========================================================
// reader top
module scmr_reader (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic config_clock_in,
  input wire logic chip_enable_n_in,
  input wire logic reset_oe_in,
  input wire logic reset_pol_inv_in,
  input wire logic prog_we_in,
  input wire logic [scmr_pkg::WADDR_W-1:0] prog_addr_in,
  input wire logic [scmr_pkg::WORD_W-1:0] prog_data_in,
  output logic data_out,
  output logic data_oe_out,
  output logic chip_enable_cascade_out_n_out
);
  import scmr_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // ==========================================================
  // pin synchronisers
  scmr_pins_t pins_raw, sync1_r, sync2_r;
  logic config_clock_d_r;
  assign pins_raw = '{config_clock: config_clock_in, ce_n: chip_enable_n_in,
                      reset_oe: reset_oe_in, pol_inv: reset_pol_inv_in};

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= PINS_RST;
      sync2_r <= PINS_RST;
      config_clock_d_r <= 1'b0;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      config_clock_d_r <= sync2_r.config_clock;
    end
  end

  // ==========================================================
  // enables and polarity
  wire config_clock_rise = sync2_r.config_clock & ~config_clock_d_r;
  // polarity is a programmed option, so it may flip reset level live
  wire rst_lvl = sync2_r.reset_oe ^ sync2_r.pol_inv; // R20
  wire oe_act = ~rst_lvl;
  wire ce_act = ~sync2_r.ce_n;
  logic past_tc_r;
  wire step = config_clock_rise & ce_act & oe_act & ~past_tc_r; // R17

  // ==========================================================
  // storage and prefetch
  logic [WORD_W-1:0] store [MEM_WORDS];
  logic [WADDR_W:0] pf_addr_r;
  logic fifo_in_ready, head_valid;
  logic [WORD_W-1:0] head_word;
  wire pf_valid = (pf_addr_r != PF_END);
  wire pf_push = pf_valid & fifo_in_ready;
  wire [WORD_W-1:0] pf_word = store[pf_addr_r[WADDR_W-1:0]];

  always_ff @(posedge mclk_in) begin
    if (prog_we_in) begin
      store[prog_addr_in] <= prog_data_in;
    end
  end

  // ==========================================================
  // bit address counter
  logic [BIT_ADDR_W-1:0] bit_addr_r, bit_addr_nxt;
  wire at_last = (bit_addr_r == LAST_BIT); // R21
  wire [3:0] bit_idx = bit_addr_r[3:0];
  wire pop = step & ((bit_idx == WORD_LAST_IDX) | at_last);
  assign bit_addr_nxt = (step & ~at_last) ? bit_addr_r + 16'h0001 : bit_addr_r;

  scmr_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .flush_in(rst_lvl),
    .in_valid_in(pf_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(pf_word),
    .out_valid_out(head_valid),
    .out_ready_in(pop),
    .out_data_out(head_word)
  );

  // power-up reset and reset level both restart from the first bit
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_addr_r <= BIT_ADDR_RST; // R10
      past_tc_r <= 1'b0;
      pf_addr_r <= PF_RST;
    end else if (rst_lvl) begin
      bit_addr_r <= BIT_ADDR_RST; // R3 R5 R13
      past_tc_r <= 1'b0;
      pf_addr_r <= PF_RST;
    end else begin
      bit_addr_r <= bit_addr_nxt; // R8 R9
      past_tc_r <= past_tc_r | (step & at_last); // R11
      pf_addr_r <= pf_addr_r + (WADDR_W+1)'(pf_push);
    end
  end

  // ==========================================================
  // pin outputs
  wire drive = ce_act & oe_act & ~past_tc_r & head_valid; // R12 R14 R18
  wire ceo_low = ce_act & oe_act & past_tc_r; // R19
  logic data_r, data_oe_r, ceo_n_r;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_r <= 1'b0;
      data_oe_r <= 1'b0;
      ceo_n_r <= 1'b1;
    end else begin
      data_r <= head_word[bit_idx] & drive;
      data_oe_r <= drive;
      ceo_n_r <= ~ceo_low;
    end
  end
  assign data_out = data_r;
  assign data_oe_out = data_oe_r;
  assign chip_enable_cascade_out_n_out = ceo_n_r;

  // ==========================================================
  // checks
  sequence s_last_step;
    step && at_last;
  endsequence

  a_reset_clears: assert property (rst_lvl |=> // R3 R5 R13
    bit_addr_r == BIT_ADDR_RST && !past_tc_r)
    else $error("counter not cleared at reset level");
  a_hold_idle: assert property ((!step && !rst_lvl) |=> // R9 R17
    $stable(bit_addr_r))
    else $error("counter moved without a valid edge");
  a_step_adv: assert property ((step && !at_last && !rst_lvl) |=> // R8
    bit_addr_r == $past(bit_addr_r) + 16'h0001)
    else $error("counter did not advance by one");
  a_tc_cascade: assert property ((s_last_step ##1 (ce_act && oe_act)) // R11
    |=> !chip_enable_cascade_out_n_out && !data_oe_out)
    else $error("cascade not low after last bit");
  a_cascade_cause: assert property (!ceo_n_r |-> // R19
    $past(ce_act && oe_act && past_tc_r))
    else $error("cascade low without cause");
  a_standby_float: assert property (!ce_act |=> !data_oe_out) // R14
    else $error("data driven in standby");
  a_oe_float: assert property (!oe_act |=> !data_oe_out) // R18
    else $error("data driven while output disabled");
  a_ce_enable: assert property (drive |=> data_oe_out) // R12
    else $error("data not enabled with chip enable low");
  a_tc_sticky: assert property ((past_tc_r && !rst_lvl) |=> past_tc_r) // R21
    else $error("terminal flag lost without reset");
endmodule

// ### tb/scmr_fpga_model.sv
/*
  Master serial configuration side: makes config clock pulses and takes
  the serial data. Assumes a pull-up on the data line of the taker.
*/
`timescale 1ns/1ps
module scmr_fpga_model (
  input wire logic mclk_in,
  input wire logic data_in,
  input wire logic data_oe_in,
  output logic config_clock_out
);
  // ==========================================================
  // pulse driver
  logic din;
  // released line floats up to the pull-up level
  assign din = data_oe_in ? data_in : 1'b1;
  // mode selects all low: this side only ever acts as serial master
  initial config_clock_out = 1'b0;
  // clock stands low between pulses; high 8 mclk, low at least 9 mclk
  task automatic pulse(output logic bit_seen);
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
    bit_seen = din;
    @(posedge mclk_in);
    config_clock_out <= 1'b1;
    repeat (8) @(posedge mclk_in);
    config_clock_out <= 1'b0;
  endtask
endmodule

// ### tb/serial_config_prom_reader_tb_top.sv
/*
  Testbench for the serial configuration memory reader.
  Assumes the design package and the master serial model are compiled.
*/
`timescale 1ns/1ps
module serial_config_prom_reader_tb_top;
  import scmr_pkg::*;
  // ==========================================================
  // stimulus and instances
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce_n = 1'b1;
  logic roe = 1'b0;
  logic pol = 1'b0;
  logic we = 1'b0;
  logic [WADDR_W-1:0] waddr = '0;
  logic [WORD_W-1:0] wdata = '0;
  logic config_clock, dout, doe, ceo_n;
  int miscompares = 0;
  int cmp_count = 0;
  always #10 mclk = ~mclk;
  scmr_reader DUT (.mclk_in(mclk), .rst_in(rst), .config_clock_in(config_clock),
    .chip_enable_n_in(ce_n), .reset_oe_in(roe), .reset_pol_inv_in(pol),
    .prog_we_in(we), .prog_addr_in(waddr), .prog_data_in(wdata),
    .data_out(dout), .data_oe_out(doe),
    .chip_enable_cascade_out_n_out(ceo_n));
  scmr_fpga_model u_fpga (.mclk_in(mclk), .data_in(dout),
    .data_oe_in(doe), .config_clock_out(config_clock));
  // ==========================================================
  // shared tasks
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic read16(output logic [15:0] w);
    logic b;
    for (int i = 0; i < 16; i++) begin
      u_fpga.pulse(b);
      w[i] = b;
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic load(logic [WADDR_W-1:0] a, logic [WORD_W-1:0] d);
    @(posedge mclk);
    we <= 1'b1;
    waddr <= a;
    wdata <= d;
    @(posedge mclk);
    we <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic test_first_word();
    logic [15:0] w;
    @(posedge mclk);
    // ce_n stands in for the upstream cascade output of a chain
    ce_n <= 1'b0;
    idle(8);
    read16(w);
    check("word0", w, 16'hA5C3);
    check("cascade", {15'h0000, ceo_n}, 16'h0001);
    $display("test_first_word done");
  endtask
  task automatic test_standby();
    logic [15:0] w;
    logic b;
    @(posedge mclk);
    ce_n <= 1'b1;
    idle(8);
    check("oe standby", {15'h0000, doe}, 16'h0000);
    check("cascade standby", {15'h0000, ceo_n}, 16'h0001);
    repeat (4) u_fpga.pulse(b);
    @(posedge mclk);
    ce_n <= 1'b0;
    idle(8);
    read16(w);
    check("word1", w, 16'h0F69);
    $display("test_standby done");
  endtask
  // p selects polarity: reset level is roe == ~p
  task automatic test_reset(logic p);
    logic [15:0] w;
    @(posedge mclk);
    pol <= p;
    roe <= p;
    idle(8);
    read16(w);
    check("resume", w, p ? 16'h0F69 : 16'h3C5A);
    @(posedge mclk);
    roe <= ~p;
    idle(8);
    check("oe in reset", {15'h0000, doe}, 16'h0000);
    @(posedge mclk);
    roe <= p;
    idle(8);
    read16(w);
    check("word0 after reset", w, 16'hA5C3);
    $display("test_reset done");
  endtask
  // ==========================================================
  // closing
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    // image goes in under reset, before prefetch starts reading storage
    load(12'h000, 16'hA5C3);
    load(12'h001, 16'h0F69);
    load(12'h002, 16'h3C5A);
    idle(6);
    rst <= 1'b0;
    idle(8);
    test_first_word();
    test_standby();
    test_reset(1'b0);
    test_reset(1'b1);
    results();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    results();
  end
endmodule
